// [verilog/air_pkg.sv]
/*
 * Constants for the interrupt routing and offset correction block.
 * Assumes a register port with an 8-bit address and 8-bit data.
 */
package air_pkg;
    localparam logic [7:0] ADDR_WAKE_CFG  = 8'h2C;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h2D;
    localparam logic [7:0] ADDR_IRQ_ROUTE = 8'h2E;
    localparam logic [7:0] ADDR_OFF_X     = 8'h2F;
    localparam logic [7:0] ADDR_OFF_Y     = 8'h30;
    localparam logic [7:0] ADDR_OFF_Z     = 8'h31;
    localparam logic [7:0] ADDR_SOURCE    = 8'h0C;

    localparam int BIT_ORIENT_WAKE = 5;
    localparam int BIT_FALL_WAKE   = 3;
    localparam int BIT_POLARITY    = 1;
    localparam int BIT_PAD_DRIVE   = 0;
    localparam int BIT_SRC_SLEEP   = 7;
    localparam int BIT_SRC_ORIENT  = 4;
    localparam int BIT_SRC_FALL    = 2;
    localparam int BIT_SRC_READY   = 0;

    localparam logic [7:0] MASK_WAKE_CFG = 8'h2B;
    localparam logic [7:0] MASK_SOURCES  = 8'h95;
    localparam logic [7:0] RESET_CFG     = 8'h00;
    localparam logic [7:0] RESET_OFFSET  = 8'h00;

    localparam int NUM_AXES = 3;
    localparam int NUM_SRC  = 4;
endpackage : air_pkg

// [verilog/air_pin_driver.sv]
/*
 * One interrupt pad: polarity and push-pull or open-drain drive.
 * Assumes the pad logic resolves the wire from output and enable.
 */
`timescale 1ns/1ps
module air_pin_driver (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic asserted,
    input  wire logic activeHigh,
    input  wire logic openDrain,
    output logic      pinOut,
    output logic      pinOeN
);
    logic nxt_pinOut;
    logic nxt_pinOeN;
    logic pinOut_ff;
    logic pinOeN_ff;

    always_comb begin
        // [R3] Asserted level select.
        nxt_pinOut = asserted ~^ activeHigh;
        // [R4] Open-drain releases the pin.
        nxt_pinOeN = openDrain && (nxt_pinOut == 1'b1);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pinOut_ff <= 1'b1;
            pinOeN_ff <= 1'b0;
        end else begin
            pinOut_ff <= nxt_pinOut;
            pinOeN_ff <= nxt_pinOeN;
        end
    end

    assign pinOut = pinOut_ff;
    assign pinOeN = pinOeN_ff;

    // Open drain never drives a high level.
    AST_OD_NO_HIGH: assert property (@(posedge clk) disable iff (reset) // [R4]
        $past(openDrain) && !$past(reset) |-> (pinOeN || !pinOut))
        else $error("open drain pin driven high");
endmodule : air_pin_driver

// [verilog/air_irq_route.sv]
/*
 * Interrupt enable, routing, wake control and axis offset registers.
 * Assumes a synchronous register port and event levels from detectors.
 */
`timescale 1ns/1ps
// Overview of operation
// [R1] Orientation events wake the system from sleep only when its wake bit is set.
// [R2] Fall or motion events wake the system from sleep only when allowed.
// [R3] Polarity bit picks the asserted level of both pins; low by default.
// [R4] Pad drive bit picks push-pull (default) or open drain for both pins.
// [R5] Enable register bits 7, 4, 2, 0 enable the four sources; default off.
// [R6] Only enabled sources reach the interrupt pins.
// [R7] Routing bit 0 sends a source to pin B, 1 to pin A.
// [R8] Any enabled source routed to a pin asserts it; host reads source.
// [R9] Each axis has a signed 8-bit offset added to its output.
// [R10] The signed offset spans about plus or minus 250 mg per axis.
// [R11] Offsets live at 0x2F to 0x31 and reset to zero.
// [R12] Unused bits in the three control registers read zero, ignore writes.
module air_irq_route (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    output logic      [7:0]  regRdata,
    input  wire logic        asleep,
    input  wire logic        evtSleepWake,
    input  wire logic        evtOrient,
    input  wire logic        evtFallMotion,
    input  wire logic        evtSampleReady,
    input  wire logic [9:0]  axisRaw [air_pkg::NUM_AXES],
    output logic      [9:0]  axisCorrected [air_pkg::NUM_AXES],
    output logic             wakeRequest,
    output logic      [7:0]  irqSource,
    output logic             irq_out_a,
    output logic             irq_out_a_oe_n,
    output logic             irq_out_b,
    output logic             irq_out_b_oe_n
);
    logic [7:0] wakeCfg_ff, nxt_wakeCfg;
    logic [7:0] irqEn_ff, nxt_irqEn;
    logic [7:0] irqRoute_ff, nxt_irqRoute;
    logic [7:0] offset_ff [air_pkg::NUM_AXES];
    logic [7:0] nxt_offset [air_pkg::NUM_AXES];
    logic [7:0] rdata_ff, nxt_rdata;
    logic [7:0] source_ff, nxt_source;
    logic       wake_ff, nxt_wake;
    logic       pinA_ff, nxt_pinA;
    logic       pinB_ff, nxt_pinB;
    logic [9:0] corr_ff [air_pkg::NUM_AXES];
    logic [9:0] nxt_corr [air_pkg::NUM_AXES];
    logic [7:0] events;

    assign events = {evtSleepWake, 2'b00, evtOrient, 1'b0,
                     evtFallMotion, 1'b0, evtSampleReady};

    // Register file next state.
    always_comb begin
        nxt_wakeCfg  = wakeCfg_ff;
        nxt_irqEn    = irqEn_ff;
        nxt_irqRoute = irqRoute_ff;
        for (int i = 0; i < air_pkg::NUM_AXES; i++) begin
            nxt_offset[i] = offset_ff[i];
        end
        if (regWrite) begin
            case (regAddr)
                // [R12] Masked control writes.
                air_pkg::ADDR_WAKE_CFG:
                    nxt_wakeCfg = regWdata & air_pkg::MASK_WAKE_CFG;
                // [R5] Source enable write.
                air_pkg::ADDR_IRQ_EN:
                    nxt_irqEn = regWdata & air_pkg::MASK_SOURCES;
                // [R7] Routing write.
                air_pkg::ADDR_IRQ_ROUTE:
                    nxt_irqRoute = regWdata & air_pkg::MASK_SOURCES;
                // [R11] Offset writes.
                air_pkg::ADDR_OFF_X: nxt_offset[0] = regWdata;
                air_pkg::ADDR_OFF_Y: nxt_offset[1] = regWdata;
                air_pkg::ADDR_OFF_Z: nxt_offset[2] = regWdata;
                default: ;
            endcase
        end
    end

    // Read data, interrupt combining, wake and offset application.
    always_comb begin
        logic [7:0] live;
        live = events & irqEn_ff;
        nxt_rdata = rdata_ff;
        if (regRead) begin
            case (regAddr)
                air_pkg::ADDR_WAKE_CFG:  nxt_rdata = wakeCfg_ff;
                air_pkg::ADDR_IRQ_EN:    nxt_rdata = irqEn_ff;
                air_pkg::ADDR_IRQ_ROUTE: nxt_rdata = irqRoute_ff;
                air_pkg::ADDR_OFF_X:     nxt_rdata = offset_ff[0];
                air_pkg::ADDR_OFF_Y:     nxt_rdata = offset_ff[1];
                air_pkg::ADDR_OFF_Z:     nxt_rdata = offset_ff[2];
                air_pkg::ADDR_SOURCE:    nxt_rdata = source_ff;
                default:                 nxt_rdata = 8'h00;
            endcase
        end
        // [R6] Enable gates each source.
        nxt_source = live;
        // [R8] Any routed source asserts.
        nxt_pinA = |(live & irqRoute_ff);
        nxt_pinB = |(live & ~irqRoute_ff);
        // [R1] Orientation wake gate.
        // [R2] Fall or motion wake gate.
        nxt_wake = asleep &&
            ((live[air_pkg::BIT_SRC_ORIENT] &&
              wakeCfg_ff[air_pkg::BIT_ORIENT_WAKE]) ||
             (live[air_pkg::BIT_SRC_FALL] &&
              wakeCfg_ff[air_pkg::BIT_FALL_WAKE]));
        // [R9] Signed offset added per axis.
        // [R10] Range follows the 8-bit sign.
        for (int i = 0; i < air_pkg::NUM_AXES; i++) begin
            nxt_corr[i] = axisRaw[i] + {{2{offset_ff[i][7]}}, offset_ff[i]};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wakeCfg_ff  <= air_pkg::RESET_CFG;
            irqEn_ff    <= air_pkg::RESET_CFG;
            irqRoute_ff <= air_pkg::RESET_CFG;
            rdata_ff    <= 8'h00;
            source_ff   <= 8'h00;
            wake_ff     <= 1'b0;
            pinA_ff     <= 1'b0;
            pinB_ff     <= 1'b0;
            for (int i = 0; i < air_pkg::NUM_AXES; i++) begin
                offset_ff[i] <= air_pkg::RESET_OFFSET;
                corr_ff[i]   <= 10'h000;
            end
        end else begin
            wakeCfg_ff  <= nxt_wakeCfg;
            irqEn_ff    <= nxt_irqEn;
            irqRoute_ff <= nxt_irqRoute;
            rdata_ff    <= nxt_rdata;
            source_ff   <= nxt_source;
            wake_ff     <= nxt_wake;
            pinA_ff     <= nxt_pinA;
            pinB_ff     <= nxt_pinB;
            for (int i = 0; i < air_pkg::NUM_AXES; i++) begin
                offset_ff[i] <= nxt_offset[i];
                corr_ff[i]   <= nxt_corr[i];
            end
        end
    end

    assign regRdata      = rdata_ff;
    assign irqSource     = source_ff;
    assign wakeRequest   = wake_ff;
    assign axisCorrected = corr_ff;

    // The pad stage adds one cycle so pins lag the source register by one.
    air_pin_driver padA (
        .clk        (clk),
        .reset      (reset),
        .asserted   (pinA_ff),
        .activeHigh (wakeCfg_ff[air_pkg::BIT_POLARITY]),
        .openDrain  (wakeCfg_ff[air_pkg::BIT_PAD_DRIVE]),
        .pinOut     (irq_out_a),
        .pinOeN     (irq_out_a_oe_n)
    );
    air_pin_driver padB (
        .clk        (clk),
        .reset      (reset),
        .asserted   (pinB_ff),
        .activeHigh (wakeCfg_ff[air_pkg::BIT_POLARITY]),
        .openDrain  (wakeCfg_ff[air_pkg::BIT_PAD_DRIVE]),
        .pinOut     (irq_out_b),
        .pinOeN     (irq_out_b_oe_n)
    );

    sequence s_orientAsleepNoWake;
        asleep && evtOrient && !wakeCfg_ff[air_pkg::BIT_ORIENT_WAKE]
            && !(evtFallMotion && irqEn_ff[air_pkg::BIT_SRC_FALL]
                 && wakeCfg_ff[air_pkg::BIT_FALL_WAKE]);
    endsequence
    AST_ORIENT_IGNORED: assert property (@(posedge clk) disable iff (reset) // [R1]
        s_orientAsleepNoWake |=> !wakeRequest)
        else $error("orientation woke while not allowed");
    AST_FALL_WAKES: assert property (@(posedge clk) disable iff (reset) // [R2]
        asleep && evtFallMotion && irqEn_ff[air_pkg::BIT_SRC_FALL]
        && wakeCfg_ff[air_pkg::BIT_FALL_WAKE] |=> wakeRequest)
        else $error("fall or motion failed to wake");
    AST_POLARITY: assert property (@(posedge clk) disable iff (reset) // [R3]
        pinA_ff && !wakeCfg_ff[air_pkg::BIT_PAD_DRIVE]
        && $stable(wakeCfg_ff) |=> irq_out_a == wakeCfg_ff[air_pkg::BIT_POLARITY])
        else $error("pin A asserted level wrong");
    AST_ENABLE_GATE: assert property (@(posedge clk) disable iff (reset) // [R6]
        !irqEn_ff[air_pkg::BIT_SRC_READY] |=> !irqSource[air_pkg::BIT_SRC_READY])
        else $error("disabled source reached controller");
    AST_ROUTE_B: assert property (@(posedge clk) disable iff (reset) // [R7]
        evtSampleReady && irqEn_ff[air_pkg::BIT_SRC_READY]
        && !irqRoute_ff[air_pkg::BIT_SRC_READY] |=> pinB_ff)
        else $error("route zero did not reach pin B");
    AST_COMBINE_A: assert property (@(posedge clk) disable iff (reset) // [R8]
        pinA_ff |-> $past(|(events & irqEn_ff & irqRoute_ff)))
        else $error("pin A without routed source");
    AST_OFFSET_RESET: assert property (@(posedge clk) // [R11]
        $past(reset) && !reset |-> offset_ff[0] == air_pkg::RESET_OFFSET)
        else $error("offset not cleared by reset");
    AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (reset) // [R12]
        (wakeCfg_ff & ~air_pkg::MASK_WAKE_CFG) == 8'h00
        && (irqEn_ff & ~air_pkg::MASK_SOURCES) == 8'h00)
        else $error("unused bit set");
    AST_OFFSET_ADD: assert property (@(posedge clk) disable iff (reset) // [R9]
        $stable(offset_ff[1]) && !$past(reset) |-> axisCorrected[1] ==
        10'($past(axisRaw[1]) + {{2{offset_ff[1][7]}}, offset_ff[1]}))
        else $error("offset not applied");
endmodule : air_irq_route

// [testbench/air_host_model.sv]
/*
 * Host side model: resolves the two interrupt lines for the watching host.
 * Assumes it is wired straight to the block's pad outputs and enables.
 */
`timescale 1ns/1ps
module air_host_model (
    input  wire logic irqOutA,
    input  wire logic irqOutAOeN,
    input  wire logic irqOutB,
    input  wire logic irqOutBOeN,
    output logic      lineA,
    output logic      lineB
);
    // shared line pull-up.
    // A released open-drain line is pulled up, so many sources can share it.
    assign lineA = irqOutAOeN ? 1'b1 : irqOutA;
    assign lineB = irqOutBOeN ? 1'b1 : irqOutB;
endmodule : air_host_model

// [testbench/tb_top.sv]
/*
 * Self-checking bench for the interrupt routing and offset block.
 * Assumes the host model resolves the pins and reads use a one-cycle port.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
    typedef struct { string nm; logic [7:0] val; } air_note_t;
    logic        clk, reset, regWrite, regRead, asleep, wakeRequest;
    logic [7:0]  regAddr, regWdata, regRdata, irqSource, expSrc;
    logic [3:0]  evt;
    logic [9:0]  axisRaw [3];
    logic [9:0]  axisCorrected [3];
    logic [7:0]  off [3];
    logic        outA, oeNA, outB, oeNB, lineA, lineB, expA, expB, pol, od;
    logic        rdSeen;
    logic [31:0] seed;
    int          err_total, compares;
    int          srcBit [4] = '{7, 4, 2, 0};
    air_note_t   noteQ [$];

    air_irq_route air_irq_route_i (.clk(clk), .reset(reset),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .asleep(asleep),
        .evtSleepWake(evt[0]), .evtOrient(evt[1]), .evtFallMotion(evt[2]),
        .evtSampleReady(evt[3]), .axisRaw(axisRaw),
        .axisCorrected(axisCorrected), .wakeRequest(wakeRequest),
        .irqSource(irqSource), .irq_out_a(outA), .irq_out_a_oe_n(oeNA),
        .irq_out_b(outB), .irq_out_b_oe_n(oeNB));
    air_host_model air_host_model_i (.irqOutA(outA), .irqOutAOeN(oeNA),
        .irqOutB(outB), .irqOutBOeN(oeNB), .lineA(lineA), .lineB(lineB));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); #2;
        regWrite = w; regRead = !w; regAddr = a; regWdata = d;
        @(posedge clk); #2;
        regWrite = 1'b0; regRead = 1'b0;
    endtask : acc

    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        noteQ.push_back('{nm, e});
        acc(1'b0, a, 8'h00);
    endtask : rd

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // Read data is registered, so it is judged one edge after the strobe.
    always @(posedge clk) rdSeen <= regRead;
    always @(negedge clk) begin
        air_note_t n;
        if (rdSeen === 1'b1) begin
            n = (noteQ.size() > 0) ? noteQ.pop_front() : '{"empty", 8'hxx};
            `CHK(n.nm, n.val, regRdata)
        end
    end

    initial begin
        #400000;
        err_total++;
        end_of_test();
    end

    initial begin
        reset = 1'b1; regWrite = 1'b0; regRead = 1'b0; regAddr = 8'h00;
        regWdata = 8'h00; asleep = 1'b0; evt = 4'h0; rdSeen = 1'b0;
        seed = 32'hf8a6_2d7e;
        foreach (axisRaw[i]) axisRaw[i] = 10'h000;
        repeat (3) @(posedge clk);
        #2 reset = 1'b0;
        for (int i = 0; i < 6; i++) rd("reset value", 8'(8'h2C + i), 8'h00);
        rd("unmapped", 8'h40, 8'h00);
        for (int i = 0; i < 4; i++) acc(1'b1, 8'(8'h2C + i % 3), 8'hFF);
        acc(1'b1, 8'h0C, 8'hFF);
        rd("wake cfg", 8'h2C, 8'h2B);
        rd("enable", 8'h2D, 8'h95);
        rd("routing", 8'h2E, 8'h95);
        rd("source", 8'h0C, 8'h00);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            off[i] = (i == 0) ? 8'h80 : seed[7:0];
            acc(1'b1, 8'(8'h2F + i), off[i]);
            rd("offset", 8'(8'h2F + i), off[i]);
        end
        repeat (4) begin
            @(posedge clk); #2;
            foreach (axisRaw[i]) begin
                seed = lfsr(seed);
                axisRaw[i] = seed[9:0];
            end
            @(posedge clk); #1;
            foreach (axisRaw[i])
                `CHK("axis", axisRaw[i] + {{2{off[i][7]}}, off[i]}, axisCorrected[i])
        end
        // Every source, route, enable, polarity and pad mode is covered.
        for (int m = 0; m < 4; m++) for (int k = 0; k < 16; k++) begin
            pol = m[1]; od = m[0];
            acc(1'b1, 8'h2C, {6'h00, m[1:0]});
            acc(1'b1, 8'h2D, k[0] ? 8'(1 << srcBit[k[3:2]]) : 8'h00);
            acc(1'b1, 8'h2E, k[1] ? 8'(1 << srcBit[k[3:2]]) : 8'h00);
            @(posedge clk); #2 evt = 4'(1 << k[3:2]);
            @(posedge clk);
            @(posedge clk); #1;
            expSrc = k[0] ? 8'(1 << srcBit[k[3:2]]) : 8'h00;
            expA = (k[0] && k[1]) ? pol : !pol;
            expB = (k[0] && !k[1]) ? pol : !pol;
            `CHK("irq source", expSrc, irqSource)
            `CHK("pin a", expA, outA)
            `CHK("pin b", expB, outB)
            `CHK("pin a enable", od && expA, oeNA)
            `CHK("pin b enable", od && expB, oeNB)
            `CHK("line a", expA, lineA)
            `CHK("line b", expB, lineB)
            rd("source reg", 8'h0C, expSrc);
            @(posedge clk); #2 evt = 4'h0;
        end
        asleep = 1'b1;
        acc(1'b1, 8'h2D, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, 8'h2C, k[0] ? (k[1] ? 8'h20 : 8'h08) : 8'h00);
            @(posedge clk); #2 evt = k[1] ? 4'h2 : 4'h4;
            @(posedge clk); #1;
            `CHK("wake", k[0], wakeRequest)
            @(posedge clk); #2 evt = 4'h0;
        end
        @(posedge clk); #2 reset = 1'b1;
        @(posedge clk); #2 reset = 1'b0;
        rd("enable after reset", 8'h2D, 8'h00);
        repeat (3) @(posedge clk);
        end_of_test();
    end
endmodule : tb_top
